// File: design/csrsm_pkg.sv
// clock select and reset/stop manager: shared constants, types and helpers
// assumes a 32-bit AXI4-Lite register bus and a single 10 MHz clock
`default_nettype none
package csrsm_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] CLK_CTRL_IDX = 8'hf0;
  localparam logic [7:0] CLK_FLAGS_IDX = 8'hf2;
  localparam logic [7:0] PLL_CFG_IDX = 8'hf6;
  // clock_control field positions
  localparam int CTL_HALT_RST = 3;
  localparam int CTL_ALT_REQ = 2;
  localparam int CTL_LPW = 0;
  // clock_flags field positions
  localparam int FL_EXT_STOP = 7;
  localparam int FL_XT_STOP = 4;
  localparam int FL_BYPASS = 3;
  localparam int FL_PLL_SEL = 0;
  // pll_config field positions
  localparam int PLL_MUL_LSB = 4;
  localparam int PLL_DIV_LSB = 0;
  // reset values
  localparam logic [7:0] FLAGS_POR = 8'h08;
  localparam logic [7:0] FLAGS_WDOG = 8'h48;
  localparam logic [7:0] FLAGS_SW = 8'h28;
  localparam logic [1:0] PLL_MUL_RST = 2'h0;
  localparam logic [2:0] PLL_DIV_OFF = 3'h7;
  // timing: reset exit count and stop exit delay in clock periods
  localparam int RST_EXIT_OSC_CYC = 79870;
  localparam int STOP_EXIT_CYC = 255;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {SRC_XTAL, SRC_DIV16, SRC_PLL, SRC_ALT} csrsm_src_e;
  typedef enum logic [2:0] {ST_RUN, ST_RST_PIN, ST_RST_CNT, ST_HALT, ST_STOP, ST_WAKE} csrsm_state_e;
  // multiplier code to factor
  function automatic logic [3:0] csrsm_mul_factor(input logic [1:0] code);
    case (code)
      2'h2: csrsm_mul_factor = 4'he;
      2'h0: csrsm_mul_factor = 4'ha;
      2'h3: csrsm_mul_factor = 4'h8;
      default: csrsm_mul_factor = 4'h6;
    endcase
  endfunction
endpackage
`default_nettype wire

// File: design/csrsm_top.sv
// clock select and reset/stop manager with AXI4-Lite register slave
// assumes pins arrive asynchronously; cpu strobes are single-cycle pulses on aclk
//
// Contract
// - alternate clock status reads 1 only when request set and clock present
// - lock bit 0 while pll off or unlocked; pll unusable then
// - hardware clears pll select on divider 111, quartz stop, low-power wfi, bypass 0
// - pll select 0 gives crystal clock, 1 gives pll output
// - active alternate clock (request set and clock present) beats all; cleared bypass beats pll select
// - pll config: multiplier bits 5:4, divider 2:0, reset 00 and 111
// - multiplier codes 10,00,11,01 give factors 14,10,8,6
// - divider codes 0..6 divide by code+1; 111 turns pll off
// - halt stops oscillator, holds clock high, only pin reset ends it
// - with watchdog enabled halt leaves oscillator running
// - three reset sources; software and watchdog flags set, pin clears both
// - low reset pin starts reset at once, over every other condition
// - watchdog timeout resets device without driving the reset pin
// - after pin release count fixed cycles before leaving reset
// - reset filter ignores short glitches; driver holds pin long enough
// - during reset registers take reset values, pins go weak pull-up
// - romless variant enters external memory mode on reset
// - stop mode halts oscillators, keeps context, clock held high
// - stop exit waits 255 periods, then interrupt and external stop flag
// - each change of the bypass bit raises an interrupt request
// - halt with reset enable resets; otherwise, with watchdog off, stops quartz, pll, unit
// - flags reset to 0x48 watchdog, 0x28 software, 0x08 power-on
`default_nettype none
module csrsm_top import csrsm_pkg::*; #(
  parameter int ADDR_W = 12,
  parameter int RST_EXIT_CYC = RST_EXIT_OSC_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic reset_pin_n,
  input wire logic alt_clock,
  input wire logic pll_lock_raw,
  input wire logic romless_strap,
  input wire logic halt_exec,
  input wire logic wait_for_irq,
  input wire logic wdog_mode_select,
  input wire logic wdog_timeout,
  input wire logic stop_request,
  input wire logic wake_request,
  output logic cpu_reset_n,
  output logic io_weak_pullup,
  output logic ext_mem_mode,
  output logic osc_enable,
  output logic pll_enable,
  output logic [3:0] pll_mult_factor,
  output logic [2:0] pll_div_ratio,
  output logic [1:0] clk_source,
  output logic clk_hold_high,
  output logic clk_irq,
  output logic stop_active
);
  // one counter serves the reset exit and the stop exit, so it must hold the longer of the two
  localparam int CNT_MAX = (RST_EXIT_CYC > STOP_EXIT_CYC) ? RST_EXIT_CYC : STOP_EXIT_CYC;
  localparam int CNT_W = $clog2(CNT_MAX + 1);

  // register decode: 0 none, 1 control, 2 flags, 3 pll config
  function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] a);
    if (a[ADDR_W-1:2] == (ADDR_W-2)'(CLK_CTRL_IDX)) reg_sel = 2'h1;
    else if (a[ADDR_W-1:2] == (ADDR_W-2)'(CLK_FLAGS_IDX)) reg_sel = 2'h2;
    else if (a[ADDR_W-1:2] == (ADDR_W-2)'(PLL_CFG_IDX)) reg_sel = 2'h3;
    else reg_sel = 2'h0;
  endfunction

  logic [3:0] sync0, sync1, sync2, pin_f;
  logic pin_low, alt_present, lock_in, romless;
  csrsm_state_e state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic halt_reset_enable, alt_clock_request, low_power_wait_enable;
  logic ext_stop_flag, wdog_reset_flag, sw_reset_flag, xtal_stop_enable;
  logic slow_clock_bypass, pll_source_select;
  logic [1:0] pll_multiplier;
  logic [2:0] pll_divider;
  logic alt_clock_active, alt_prev, bypass_prev;
  logic pll_on, pll_run, pll_lock, quartz_off, in_reset, frozen;
  logic sw_evt, wdog_evt, wake_done, wr_en;
  logic [1:0] sw_phase, next_phase;
  csrsm_src_e target;

  // pin synchronisers; a level is accepted once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync0 <= 4'h0;
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      pin_f <= 4'h0;
    end else if (clk_en) begin
      sync0 <= {romless_strap, pll_lock_raw, alt_clock, reset_pin_n};
      sync1 <= sync0;
      sync2 <= sync1;
      pin_f <= (sync1 & sync2) | (pin_f & (sync1 | sync2));
    end
  end

  assign pin_low = !pin_f[0];
  assign alt_present = pin_f[1];
  assign lock_in = pin_f[2];
  assign romless = pin_f[3];

  // derived clock conditions
  assign pll_on = slow_clock_bypass && (pll_divider != PLL_DIV_OFF);
  assign quartz_off = xtal_stop_enable && alt_clock_active;
  assign pll_lock = pll_on && lock_in && !quartz_off;
  assign in_reset = (state == ST_RST_PIN) || (state == ST_RST_CNT);
  assign frozen = (state == ST_HALT) || (state == ST_STOP) || (state == ST_WAKE);
  assign pll_run = pll_on && !frozen && !quartz_off;
  assign sw_evt = (state == ST_RUN) && halt_exec && halt_reset_enable;
  assign wdog_evt = (state == ST_RUN) && wdog_timeout && wdog_mode_select;
  assign wake_done = (state == ST_WAKE) && (cnt == CNT_W'(STOP_EXIT_CYC - 1));
  assign wr_en = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];

  // source priority: alternate, then divide-by-16, then locked pll, else crystal
  always_comb begin
    if (alt_clock_active) target = SRC_ALT;
    else if (!slow_clock_bypass) target = SRC_DIV16;
    else if (pll_source_select && pll_lock) target = SRC_PLL;
    else target = SRC_XTAL;
  end

  // reset, halt and stop sequencing
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    if (pin_low) begin
      next_state = ST_RST_PIN;
      next_cnt = '0;
    end else begin
      case (state)
        ST_RST_PIN: begin
          next_state = ST_RST_CNT;
          next_cnt = '0;
        end
        ST_RST_CNT: begin
          if (cnt == CNT_W'(RST_EXIT_CYC - 1)) next_state = ST_RUN;
          else next_cnt = cnt + 1'b1;
        end
        ST_RUN: begin
          if (sw_evt || wdog_evt) begin
            next_state = ST_RST_CNT;
            next_cnt = '0;
          end else if (halt_exec && !wdog_mode_select) begin
            next_state = ST_HALT;
          end else if (stop_request) begin
            next_state = ST_STOP;
          end
        end
        ST_HALT: next_state = ST_HALT;
        ST_STOP: begin
          if (wake_request) begin
            next_state = ST_WAKE;
            next_cnt = '0;
          end
        end
        ST_WAKE: begin
          if (wake_done) next_state = ST_RUN;
          else next_cnt = cnt + 1'b1;
        end
        default: next_state = ST_RST_PIN;
      endcase
    end
  end

  // state and counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_RST_PIN;
      cnt <= '0;
    end else if (clk_en) begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // system registers: reload on each reset source, else bus writes and hardware updates
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {ext_stop_flag, wdog_reset_flag, sw_reset_flag, xtal_stop_enable} <= FLAGS_POR[7:4];
      slow_clock_bypass <= FLAGS_POR[FL_BYPASS];
      pll_source_select <= FLAGS_POR[FL_PLL_SEL];
      {halt_reset_enable, alt_clock_request, low_power_wait_enable} <= 3'h0;
      pll_multiplier <= PLL_MUL_RST;
      pll_divider <= PLL_DIV_OFF;
    end else if (clk_en) begin
      if (pin_low || sw_evt || wdog_evt) begin
        if (pin_low) {ext_stop_flag, wdog_reset_flag, sw_reset_flag, xtal_stop_enable} <= FLAGS_POR[7:4];
        else if (sw_evt) {ext_stop_flag, wdog_reset_flag, sw_reset_flag, xtal_stop_enable} <= FLAGS_SW[7:4];
        else {ext_stop_flag, wdog_reset_flag, sw_reset_flag, xtal_stop_enable} <= FLAGS_WDOG[7:4];
        slow_clock_bypass <= FLAGS_POR[FL_BYPASS];
        pll_source_select <= FLAGS_POR[FL_PLL_SEL];
        {halt_reset_enable, alt_clock_request, low_power_wait_enable} <= 3'h0;
        pll_multiplier <= PLL_MUL_RST;
        pll_divider <= PLL_DIV_OFF;
      end else if (!in_reset) begin
        if (wr_en && reg_sel(s_axi_awaddr) == 2'h1) begin
          halt_reset_enable <= s_axi_wdata[CTL_HALT_RST];
          alt_clock_request <= s_axi_wdata[CTL_ALT_REQ];
          low_power_wait_enable <= s_axi_wdata[CTL_LPW];
        end
        if (wr_en && reg_sel(s_axi_awaddr) == 2'h2) begin
          if (!s_axi_wdata[FL_EXT_STOP]) ext_stop_flag <= 1'b0;
          xtal_stop_enable <= s_axi_wdata[FL_XT_STOP];
          slow_clock_bypass <= s_axi_wdata[FL_BYPASS];
          pll_source_select <= s_axi_wdata[FL_PLL_SEL];
        end
        if (wr_en && reg_sel(s_axi_awaddr) == 2'h3) begin
          pll_multiplier <= s_axi_wdata[PLL_MUL_LSB +: 2];
          pll_divider <= s_axi_wdata[PLL_DIV_LSB +: 3];
        end
        // hardware clear of pll select, after any write in the same cycle
        if ((wr_en && reg_sel(s_axi_awaddr) == 2'h3 && s_axi_wdata[PLL_DIV_LSB +: 3] == PLL_DIV_OFF)
            || pll_divider == PLL_DIV_OFF || quartz_off || frozen
            || (wait_for_irq && low_power_wait_enable)
            || (wr_en && reg_sel(s_axi_awaddr) == 2'h2 && !s_axi_wdata[FL_BYPASS])) begin
          pll_source_select <= 1'b0;
        end
        if (wake_done) ext_stop_flag <= 1'b1;
      end
    end
  end

  // alternate clock takes effect only when present; change detectors for interrupts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alt_clock_active <= 1'b0;
      alt_prev <= 1'b0;
      bypass_prev <= FLAGS_POR[FL_BYPASS];
      clk_irq <= 1'b0;
    end else if (clk_en) begin
      alt_clock_active <= alt_clock_request && alt_present && !in_reset;
      alt_prev <= alt_clock_active;
      bypass_prev <= slow_clock_bypass;
      clk_irq <= (bypass_prev != slow_clock_bypass) || (alt_prev != alt_clock_active) || wake_done;
    end
  end

  // switch sequencer: hold clock high, change source, then release
  always_comb begin
    case (sw_phase)
      2'h0: next_phase = (csrsm_src_e'(clk_source) != target) ? 2'h1 : 2'h0;
      2'h1: next_phase = 2'h2;
      default: next_phase = 2'h0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_phase <= 2'h0;
      clk_source <= SRC_XTAL;
      clk_hold_high <= 1'b1;
    end else if (clk_en) begin
      sw_phase <= next_phase;
      if (sw_phase == 2'h1) clk_source <= target;
      clk_hold_high <= (next_phase != 2'h0) || (next_state == ST_HALT) || (next_state == ST_STOP)
                       || (next_state == ST_WAKE);
    end
  end

  // device-level outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_reset_n <= 1'b0;
      io_weak_pullup <= 1'b1;
      ext_mem_mode <= 1'b0;
      osc_enable <= 1'b1;
      pll_enable <= 1'b0;
      pll_mult_factor <= 4'h0;
      pll_div_ratio <= 3'h0;
      stop_active <= 1'b0;
    end else if (clk_en) begin
      cpu_reset_n <= (next_state == ST_RUN) || (next_state == ST_HALT) || (next_state == ST_STOP)
                     || (next_state == ST_WAKE);
      io_weak_pullup <= (next_state == ST_RST_PIN) || (next_state == ST_RST_CNT);
      if (in_reset) ext_mem_mode <= romless;
      osc_enable <= !((next_state == ST_HALT) || (next_state == ST_STOP) || quartz_off);
      pll_enable <= pll_run;
      pll_mult_factor <= pll_run ? csrsm_mul_factor(pll_multiplier) : 4'h0;
      pll_div_ratio <= pll_run ? pll_divider + 3'h1 : 3'h0;
      stop_active <= (next_state == ST_STOP) || (next_state == ST_WAKE);
    end
  end

  // AXI4-Lite write channel: take address and data together, answer one cycle later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (clk_en) begin
      s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (reg_sel(s_axi_awaddr) == 2'h0) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (clk_en) begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= (reg_sel(s_axi_araddr) == 2'h0) ? RESP_SLVERR : RESP_OKAY;
        case (reg_sel(s_axi_araddr))
          2'h1: s_axi_rdata <= {28'h0, halt_reset_enable, alt_clock_request, 1'b0, low_power_wait_enable};
          2'h2: s_axi_rdata <= {24'h0, ext_stop_flag, wdog_reset_flag, sw_reset_flag, quartz_off,
                                slow_clock_bypass, alt_clock_active, pll_lock, pll_source_select};
          2'h3: s_axi_rdata <= {26'h0, pll_multiplier, 1'b0, pll_divider};
          default: s_axi_rdata <= 32'h0;
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // csrsm_top
`default_nettype wire

// File: bench/csrsm_checker.sv
// checker: port timing of the clock select and reset/stop manager
// assumes binding into csrsm_top; one clock, synchronous active-low reset
`default_nettype none
module csrsm_checker import csrsm_pkg::*; #(
  parameter int RST_EXIT_CYC = RST_EXIT_OSC_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic reset_pin_n,
  input wire logic alt_clock,
  input wire logic cpu_reset_n,
  input wire logic osc_enable,
  input wire logic pll_enable,
  input wire logic [3:0] pll_mult_factor,
  input wire logic [2:0] pll_div_ratio,
  input wire logic [1:0] clk_source,
  input wire logic clk_hold_high,
  input wire logic clk_irq,
  input wire logic stop_active
);
  timeunit 1ns;
  timeprecision 1ns;
  int stop_cnt;
  int exit_cnt;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // helper counters: length of stop, length of reset with the pin released
  always_ff @(posedge aclk) begin
    stop_cnt <= stop_active ? stop_cnt + 1 : 0;
    exit_cnt <= (aresetn && !cpu_reset_n && reset_pin_n) ? exit_cnt + 1 : 0;
  end
  sequence s_stop_leave;
    $fell(stop_active);
  endsequence
  a_pll_lock_use: assert property ((clk_source == 2'h2 && !clk_hold_high) |-> pll_enable)
    else $error("pll chosen while off");
  a_pll_code_map: assert property (pll_enable ? (pll_mult_factor inside {4'he, 4'ha, 4'h8, 4'h6}
    && pll_div_ratio != 3'h0) : (pll_div_ratio == 3'h0)) else $error("pll factor out of table");
  a_switch_clean: assert property ($changed(clk_source) |-> clk_hold_high && $past(clk_hold_high))
    else $error("source changed outside hold");
  a_alt_needs_clock: assert property ((!alt_clock) [*8] |-> clk_source != 2'h3)
    else $error("alt source without clock");
  a_pin_reset_fast: assert property ((!reset_pin_n) [*6] |-> !cpu_reset_n)
    else $error("pin low but not in reset");
  a_stop_freeze: assert property ($rose(stop_active) |-> ##[0:3] (clk_hold_high && !osc_enable))
    else $error("stop without frozen clock");
  a_stop_leave_wait: assert property (s_stop_leave |-> stop_cnt >= 255 ##[0:2] clk_irq)
    else $error("stop left early or silently");
  a_exit_count: assert property ($rose(cpu_reset_n) |-> exit_cnt >= RST_EXIT_CYC - 1
    && exit_cnt <= RST_EXIT_CYC + 10) else $error("reset exit count wrong");
endmodule // csrsm_checker
bind csrsm_top csrsm_checker #(.RST_EXIT_CYC(RST_EXIT_CYC)) u_chk (.*);
`default_nettype wire

// File: bench/csrsm_pin_model.sv
// partner model: crystal side lock, alternate clock presence and reset pin driver
// assumes requests from the bench arrive just after rising edges
`default_nettype none
module csrsm_pin_model (
  input wire logic aclk,
  input wire logic rst_req,
  input wire logic glitch_req,
  input wire logic alt_on,
  input wire logic pll_enable,
  output logic reset_pin_n,
  output logic alt_clock,
  output logic pll_lock_raw
);
  timeunit 1ns;
  timeprecision 1ns;
  int lk = 0;
  // pin low for a held request or a one-cycle glitch; lock after settling
  always @(posedge aclk) begin
    reset_pin_n <= !(rst_req || glitch_req);
    lk <= pll_enable ? lk + 1 : 0;
    pll_lock_raw <= pll_enable && lk > 3;
  end
  assign alt_clock = alt_on; // presence level only
endmodule // csrsm_pin_model
`default_nettype wire

// File: bench/csrsm_top_tb.sv
// testbench: register bus, clock choice, reset sources, halt and stop
// assumes csrsm_top with a short reset exit count, the pin model and bound checker
`default_nettype none
module csrsm_top_tb import csrsm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int XC = 20;
  logic aclk, aresetn, clk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, reset_pin_n, alt_clock;
  logic pll_lock_raw, romless_strap, halt_exec, wait_for_irq, wdog_mode_select, wdog_timeout, stop_request;
  logic wake_request, cpu_reset_n, io_weak_pullup, ext_mem_mode, osc_enable, pll_enable, clk_hold_high;
  logic clk_irq, stop_active, rst_req, glitch_req, alt_on;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_v, w;
  logic [3:0] s_axi_wstrb, pll_mult_factor;
  logic [1:0] s_axi_bresp, s_axi_rresp, clk_source, rsp;
  logic [2:0] pll_div_ratio;
  logic [5:0] pls;
  logic [31:0] seed = 32'hed5e6bec;
  int err_total, tests_run, irq_n, b;
  int mf[4] = '{10, 6, 14, 8};
  int fl[3] = '{32'h28, 32'h48, 32'h08};
  assign {stop_request, wake_request, wdog_timeout, halt_exec, wait_for_irq, glitch_req} = pls;
  csrsm_top #(.RST_EXIT_CYC(XC)) u_dut (.*);
  csrsm_pin_model u_pins (.*);
  // clock generation and interrupt pulse count
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk) if (clk_irq === 1'b1) irq_n++;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic hang(input string nm);
    err_total++;
    $display("[ERR] %s expected done seen timeout", nm);
    finish_test();
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] ix, input logic [31:0] d);
    int n;
    s_axi_awaddr <= {2'h0, ix, 2'h0};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 60; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    rsp = s_axi_bresp;
    if (n == 60) hang("bus write");
  endtask
  task automatic rd(input logic [7:0] ix);
    int n;
    s_axi_araddr <= {2'h0, ix, 2'h0};
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 60; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    rd_v = s_axi_rdata;
    rsp = s_axi_rresp;
    if (n == 60) hang("bus read");
  endtask
  task automatic pulse(input int i);
    pls[i] <= 1'b1;
    @(posedge aclk);
    pls[i] <= 1'b0;
  endtask
  task automatic up();
    int n;
    for (n = 0; n < 200 && cpu_reset_n !== 1'b1; n++) @(posedge aclk);
    if (n == 200) hang("reset exit");
  endtask
  task automatic pin();
    rst_req <= 1'b1;
    cyc(8);
    chk("pin reset", 32'h0, cpu_reset_n);
    chk("pullup", 32'h1, io_weak_pullup);
    rst_req <= 1'b0;
    up();
  endtask
  // run limit
  initial begin
    cyc(20000);
    hang("run");
  end
  // main sequence
  initial begin
    {clk_en, s_axi_bready, s_axi_rready, s_axi_wstrb} = 7'h7f;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, rst_req, alt_on, wdog_mode_select, romless_strap} = 8'h0;
    {pls, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    cyc(4);
    aresetn <= 1'b1;
    up();
    rd(CLK_FLAGS_IDX);
    chk("flags", 32'h08, rd_v);
    rd(CLK_CTRL_IDX);
    chk("control", 32'h00, rd_v);
    rd(8'h11);
    chk("unmapped resp", 32'h2, rsp);
    chk("unmapped data", 32'h0, rd_v);
    wr(8'h11, 32'h5a);
    chk("unmapped write", 32'h2, rsp);
    for (int m = 0; m < 4; m++) begin
      w = (rnd() & 32'hffffffc8) | (m << 4) | (rnd() % 7);
      wr(PLL_CFG_IDX, w);
      rd(PLL_CFG_IDX);
      chk("pll_config", w & 32'h37, rd_v);
      cyc(4);
      chk("mult", mf[m], pll_mult_factor);
      chk("div", w[2:0] + 1, pll_div_ratio);
    end
    for (int k = 0; k < 3; k++) begin
      wr(PLL_CFG_IDX, 32'h01);
      wr(CLK_CTRL_IDX, 32'h01);
      cyc(12);
      wr(CLK_FLAGS_IDX, 32'h09);
      cyc(4);
      chk("pll source", SRC_PLL, clk_source);
      rd(CLK_FLAGS_IDX);
      chk("lock", 32'h3, rd_v & 3);
      w = irq_n;
      case (k)
        0: wr(PLL_CFG_IDX, 32'h07);
        1: pulse(1);
        default: wr(CLK_FLAGS_IDX, 32'h01);
      endcase
      cyc(4);
      rd(CLK_FLAGS_IDX);
      chk("select cleared", 32'h0, rd_v & 1);
    end
    chk("bypass irq", 32'h1, irq_n - w);
    chk("slow source", SRC_DIV16, clk_source);
    chk("pll off", 32'h0, pll_enable);
    wr(CLK_FLAGS_IDX, 32'h08);
    wr(CLK_CTRL_IDX, 32'h04);
    cyc(8);
    rd(CLK_FLAGS_IDX);
    chk("alt absent", 32'h0, rd_v & 4);
    alt_on <= 1'b1;
    cyc(10);
    rd(CLK_FLAGS_IDX);
    chk("alt active", 32'h4, rd_v & 4);
    chk("alt source", SRC_ALT, clk_source);
    alt_on <= 1'b0;
    wr(CLK_CTRL_IDX, 32'h00);
    for (int r = 0; r < 3; r++) begin
      wr(PLL_CFG_IDX, 32'h21);
      wr(CLK_CTRL_IDX, 32'h08);
      w = rnd();
      romless_strap <= w[0];
      wdog_mode_select <= (r == 1);
      if (r == 2) pin();
      else pulse(2 + r);
      cyc(3);
      up();
      rd(CLK_FLAGS_IDX);
      chk("reset flags", fl[r], rd_v & 32'he8);
      rd(PLL_CFG_IDX);
      chk("reloaded", 32'h07, rd_v);
      chk("romless", w[0], ext_mem_mode);
    end
    pulse(0);
    cyc(8);
    chk("glitch", 32'h1, cpu_reset_n);
    wdog_mode_select <= 1'b1;
    pulse(2);
    cyc(4);
    chk("halt wdog osc", 32'h1, osc_enable);
    wdog_mode_select <= 1'b0;
    pulse(2);
    cyc(4);
    chk("halt clock", 32'h1, clk_hold_high & ~osc_enable);
    pulse(4);
    cyc(4);
    chk("halt held", 32'h0, osc_enable);
    pin();
    chk("halt exit", 32'h1, osc_enable);
    pulse(5);
    cyc(6);
    chk("stop", 32'h1, stop_active & clk_hold_high & ~osc_enable);
    pulse(4);
    for (b = 0; b < 400 && stop_active !== 1'b0; b++) @(posedge aclk);
    if (b == 400) hang("stop exit");
    chk("stop wait", 32'h1, b > 253);
    rd(CLK_FLAGS_IDX);
    chk("ext stop", 32'h80, rd_v & 32'h80);
    wr(CLK_FLAGS_IDX, 32'h08);
    rd(CLK_FLAGS_IDX);
    chk("ext stop clear", 32'h0, rd_v & 32'h80);
    finish_test();
  end
endmodule // csrsm_top_tb
`default_nettype wire
